// *** logic/light_sensor_pkg.sv ***
// Constants shared by the light sensor serial register port.
package light_sensor_pkg;
  localparam logic [5:0] ADDR_FIXED_BITS = 6'h22;
  localparam logic [7:0] OFS_OPERATION_COMMAND = 8'h00;
  localparam logic [7:0] OFS_GAIN_SETTING = 8'h01;
  localparam logic [7:0] OFS_LIGHT_COUNT_LOW = 8'h04;
  localparam logic [7:0] OFS_LIGHT_COUNT_HIGH = 8'h05;
  localparam logic [7:0] OFS_CYCLE_COUNT_LOW = 8'h06;
  localparam logic [7:0] OFS_CYCLE_COUNT_HIGH = 8'h07;
  localparam int RESTART_CMD_BIT = 7;
  localparam int INT_CLEAR_CMD_BIT = 6;
  localparam logic [7:0] OPERATION_COMMAND_RST = 8'h00;
  localparam logic [7:0] GAIN_SETTING_RST = 8'h00;
  localparam logic [7:0] OPERATION_COMMAND_MASK = 8'hef;
  localparam logic [7:0] GAIN_SETTING_MASK = 8'h0c;
  localparam int CONVERTER_ENABLE_BIT = 7;
  localparam int CONVERTER_POWER_DOWN_BIT = 6;
  localparam int TIMING_SOURCE_SELECT_BIT = 5;
  localparam int DIODE_MODE_HI_BIT = 3;
  localparam int DIODE_MODE_LO_BIT = 2;
  localparam int CYCLE_WIDTH_HI_BIT = 1;
  localparam int CYCLE_WIDTH_LO_BIT = 0;
  localparam int RANGE_SELECT_HI_BIT = 3;
  localparam int RANGE_SELECT_LO_BIT = 2;
  localparam logic [1:0] DIODE_MODE_LIGHT = 2'h2;
  localparam logic [16:0] CYCLES_W00 = 17'h10000;
  localparam logic [16:0] CYCLES_W01 = 17'h01000;
  localparam logic [16:0] CYCLES_W10 = 17'h00100;
  localparam logic [16:0] CYCLES_W11 = 17'h00010;
  localparam logic [14:0] LIGHT_COUNT_MAX = 15'h7fff;
endpackage

// *** logic/integration_timer.sv ***
// Integration timer and light accumulator running on the oscillator clock.
`timescale 1ns/1ps
module integration_timer
  import light_sensor_pkg::*;
(
  input wire logic osc_clk_i,
  input wire logic osc_rst_i,
  input wire logic active_i,
  input wire logic external_i,
  input wire logic [1:0] width_i,
  input wire logic [1:0] range_i,
  input wire logic photo_pulse_i,
  input wire logic restart_i,
  output logic done_tgl_o,
  output logic [15:0] light_o,
  output logic [15:0] cycles_o
);
  // All oscillator-side state lives in one record.
  typedef struct packed {
    logic [16:0] cnt;
    logic [15:0] acc;
    logic [15:0] light;
    logic [15:0] cycles;
    logic done_tgl;
  } tmr_s;
  tmr_s s_r, s_nxt;
  logic [16:0] limit;
  logic [15:0] step;
  logic finish;

  // Programmed cycle count per conversion.
  always_comb begin
    case (width_i)
      2'h0: limit = CYCLES_W00;
      2'h1: limit = CYCLES_W01;
      2'h2: limit = CYCLES_W10;
      default: limit = CYCLES_W11;
    endcase
    // Lower ranges weigh each photo pulse more, for dim light.
    step = 16'h0001 << (2'h3 - range_i);
  end

  // Finish by count internally, or by the host restart externally.
  assign finish = external_i ? restart_i : (s_r.cnt + 17'h1 >= limit);

  // Count, accumulate and capture both results together.
  always_comb begin
    s_nxt = s_r;
    if (!active_i) begin
      // Converter held in reset.
      s_nxt.cnt = '0;
      s_nxt.acc = '0;
    end else if (finish) begin
      s_nxt.light = s_r.acc;
      s_nxt.cycles = s_r.cnt[15:0] + 16'h1;
      s_nxt.done_tgl = ~s_r.done_tgl;
      s_nxt.cnt = '0;
      s_nxt.acc = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 17'h1;
      if (photo_pulse_i) begin
        // Saturate at the 15-bit full scale, below the sign bit.
        if ({1'b0, s_r.acc} + {1'b0, step} > {2'h0, LIGHT_COUNT_MAX}) begin
          s_nxt.acc = {1'b0, LIGHT_COUNT_MAX};
        end else begin
          s_nxt.acc = s_r.acc + step;
        end
      end
    end
  end

  // Register the record.
  always_ff @(posedge osc_clk_i) begin
    if (osc_rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done_tgl_o = s_r.done_tgl;
  assign light_o = s_r.light;
  assign cycles_o = s_r.cycles;

  // A saturating accumulator must never spill into the sign bit.
  a_light_range: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst_i)
    s_r.light <= {1'b0, LIGHT_COUNT_MAX})
    else $error("Light count beyond 15 bits.");
  // A disabled converter keeps its counter cleared.
  a_hold_reset: assert property (
    @(posedge osc_clk_i) disable iff (osc_rst_i)
    !active_i |=> s_r.cnt == '0)
    else $error("Counter ran while converter disabled.");
endmodule

// *** logic/light_sensor_i2c_register_port.sv ***
// Serial register port of the ambient light sensor.
`timescale 1ns/1ps
module light_sensor_i2c_register_port
  import light_sensor_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic osc_clk_i,
  input wire logic osc_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic address_select_pin_i,
  input wire logic photo_pulse_i,
  output logic converter_power_down_o,
  output logic [1:0] range_select_o,
  output logic interrupt_clear_o
);
  import light_sensor_pkg::*;

  // Serial engine states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h2,
    ST_WRITE = 3'h3,
    ST_READ = 3'h4,
    ST_RACK = 3'h5
  } phase_e;

  // All system-side state.
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    phase_e phase;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic is_read;
    logic have_ptr;
    logic [7:0] ptr;
    logic [7:0] command;
    logic [7:0] gain;
    logic sda_drive;
    logic restart_tgl;
    logic clr_pulse;
    logic [2:0] done_sync;
    logic [15:0] light;
    logic [15:0] cycles;
    logic [1:0] pin_sync;
  } port_s;
  port_s s_r, s_nxt;

  // Oscillator-side views, then system-side bus and read decodes.
  logic [2:0] rst_sync_r;
  logic [1:0] act_sync_r, ext_sync_r;
  logic [1:0] w0_sync_r, w1_sync_r, g0_sync_r, g1_sync_r;
  logic restart_pulse;
  logic done_tgl;
  logic [15:0] light_w, cycles_w;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] rd_byte;
  logic light_mode;

  // Bus edges seen only after the two-stage synchronisers.
  assign scl_rise = s_r.scl_sync[1] & ~s_r.scl_d;
  assign scl_fall = ~s_r.scl_sync[1] & s_r.scl_d;
  assign start_c = s_r.scl_sync[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_sync[1];
  assign stop_c = s_r.scl_sync[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_sync[1];
  assign light_mode = s_r.command[DIODE_MODE_HI_BIT:DIODE_MODE_LO_BIT]
    == DIODE_MODE_LIGHT;

  // Register read mux; unmapped offsets read zero.
  always_comb begin
    case (s_r.ptr)
      OFS_OPERATION_COMMAND: rd_byte = s_r.command;
      OFS_GAIN_SETTING: rd_byte = s_r.gain;
      OFS_LIGHT_COUNT_LOW: rd_byte = s_r.light[7:0];
      OFS_LIGHT_COUNT_HIGH: rd_byte = s_r.light[15:8];
      OFS_CYCLE_COUNT_LOW: rd_byte = s_r.cycles[7:0];
      OFS_CYCLE_COUNT_HIGH: rd_byte = s_r.cycles[15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  // Serial protocol engine and register updates.
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_sync = {s_r.scl_sync[0], scl_i};
    s_nxt.sda_sync = {s_r.sda_sync[0], sda_i};
    s_nxt.pin_sync = {s_r.pin_sync[0], address_select_pin_i};
    s_nxt.scl_d = s_r.scl_sync[1];
    s_nxt.sda_d = s_r.sda_sync[1];
    s_nxt.done_sync = {s_r.done_sync[1:0], done_tgl};
    s_nxt.clr_pulse = 1'b0;
    // Capture both result words in one step so halves match.
    if (s_r.done_sync[2] != s_r.done_sync[1]) begin
      s_nxt.light = light_w;
      s_nxt.cycles = cycles_w;
    end
    if (start_c) begin
      // A repeated start keeps the pointer for the read.
      s_nxt.phase = ST_ADDR;
      s_nxt.bitn = 4'h0;
      s_nxt.sda_drive = 1'b0;
    end else if (stop_c) begin
      s_nxt.phase = ST_IDLE;
      s_nxt.sda_drive = 1'b0;
    end else begin
      case (s_r.phase)
        ST_IDLE: s_nxt.sda_drive = 1'b0;
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            s_nxt.shift = {s_r.shift[6:0], s_r.sda_sync[1]};
            s_nxt.bitn = s_r.bitn + 4'h1;
          end
          if (scl_fall && s_r.bitn == 4'h8) begin
            s_nxt.bitn = 4'h0;
            if (s_r.phase == ST_ADDR) begin
              if (s_r.shift[7:1] == {ADDR_FIXED_BITS, s_r.pin_sync[1]}) begin
                s_nxt.is_read = s_r.shift[0];
                s_nxt.have_ptr = 1'b0;
                s_nxt.sda_drive = 1'b1;
                s_nxt.phase = ST_ACK;
              end else begin
                s_nxt.phase = ST_IDLE;
              end
            end else begin
              s_nxt.sda_drive = 1'b1;
              s_nxt.phase = ST_ACK;
              if (!s_r.have_ptr) begin
                s_nxt.have_ptr = 1'b1;
                s_nxt.ptr = s_r.shift;
                // Command address bits act at once; restart only under external timing.
                if (s_r.shift[RESTART_CMD_BIT] &&
                    s_r.command[TIMING_SOURCE_SELECT_BIT]) begin
                  s_nxt.restart_tgl = ~s_r.restart_tgl;
                end
                if (s_r.shift[INT_CLEAR_CMD_BIT]) begin
                  s_nxt.clr_pulse = 1'b1;
                end
              end else begin
                // Only host writes alter these two registers.
                if (s_r.ptr == OFS_OPERATION_COMMAND) begin
                  s_nxt.command = s_r.shift & OPERATION_COMMAND_MASK;
                end else if (s_r.ptr == OFS_GAIN_SETTING) begin
                  s_nxt.gain = s_r.shift & GAIN_SETTING_MASK;
                end
                s_nxt.ptr = s_r.ptr + 8'h1;
              end
            end
          end
        end
        ST_ACK: begin
          // After the acknowledge clock, release for a write or present the first read bit.
          if (scl_fall) begin
            if (s_r.is_read) begin
              s_nxt.phase = ST_READ;
              s_nxt.shift = rd_byte;
              s_nxt.sda_drive = ~rd_byte[7];
              s_nxt.bitn = 4'h1;
            end else begin
              s_nxt.sda_drive = 1'b0;
              s_nxt.phase = ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (s_r.bitn == 4'h8) begin
              s_nxt.sda_drive = 1'b0;
              s_nxt.phase = ST_RACK;
              s_nxt.ptr = s_r.ptr + 8'h1;
            end else begin
              s_nxt.sda_drive = ~s_r.shift[3'h7 - s_r.bitn[2:0]];
              s_nxt.bitn = s_r.bitn + 4'h1;
            end
          end
        end
        ST_RACK: begin
          // Master acknowledge keeps reading; a no-ack ends it.
          if (scl_rise) begin
            s_nxt.phase = s_r.sda_sync[1] ? ST_IDLE : ST_ACK;
          end
        end
        default: s_nxt.phase = ST_IDLE;
      endcase
    end
  end

  // Register the system-side record.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.command <= OPERATION_COMMAND_RST;
      s_r.gain <= GAIN_SETTING_RST;
      s_r.scl_sync <= 2'h3;
      s_r.sda_sync <= 2'h3;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Data pin is only ever pulled low; clock is never driven.
  assign sda_o = 1'b0;
  assign sda_oe_o = s_r.sda_drive;
  assign converter_power_down_o = s_r.command[CONVERTER_POWER_DOWN_BIT];
  assign range_select_o = s_r.gain[RANGE_SELECT_HI_BIT:RANGE_SELECT_LO_BIT];
  assign interrupt_clear_o = s_r.clr_pulse;

  // Configuration levels and the restart toggle crossed into the oscillator domain.
  always_ff @(posedge osc_clk_i) begin
    if (osc_rst_i) begin
      act_sync_r <= 2'h0;
      ext_sync_r <= 2'h0;
      w0_sync_r <= 2'h0;
      w1_sync_r <= 2'h0;
      g0_sync_r <= 2'h0;
      g1_sync_r <= 2'h0;
      rst_sync_r <= 3'h0;
    end else begin
      act_sync_r <= {act_sync_r[0], s_r.command[CONVERTER_ENABLE_BIT] &
        light_mode & ~s_r.command[CONVERTER_POWER_DOWN_BIT]};
      ext_sync_r <= {ext_sync_r[0], s_r.command[TIMING_SOURCE_SELECT_BIT]};
      w0_sync_r <= {w0_sync_r[0], s_r.command[CYCLE_WIDTH_LO_BIT]};
      w1_sync_r <= {w1_sync_r[0], s_r.command[CYCLE_WIDTH_HI_BIT]};
      g0_sync_r <= {g0_sync_r[0], s_r.gain[RANGE_SELECT_LO_BIT]};
      g1_sync_r <= {g1_sync_r[0], s_r.gain[RANGE_SELECT_HI_BIT]};
      rst_sync_r <= {rst_sync_r[1:0], s_r.restart_tgl};
    end
  end
  assign restart_pulse = rst_sync_r[2] ^ rst_sync_r[1];

  integration_timer u_timer (
    .osc_clk_i(osc_clk_i),
    .osc_rst_i(osc_rst_i),
    .active_i(act_sync_r[1]),
    .external_i(ext_sync_r[1]),
    .width_i({w1_sync_r[1], w0_sync_r[1]}),
    .range_i({g1_sync_r[1], g0_sync_r[1]}),
    .photo_pulse_i(photo_pulse_i),
    .restart_i(restart_pulse),
    .done_tgl_o(done_tgl),
    .light_o(light_w),
    .cycles_o(cycles_w)
  );

  // Only a host data byte may alter the command register.
  a_ctrl_stable: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_r.phase != ST_WRITE |=> $stable(s_r.command))
    else $error("Command register changed outside a write.");
  // An idle port never pulls the data line.
  a_no_ack_foreign: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    s_r.phase == ST_IDLE && !start_c |=> !s_r.sda_drive)
    else $error("Data pin driven while idle.");
  // The light result word moves only on a capture from the oscillator side.
  a_data_pair: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    $changed(s_r.light) |-> $past(s_r.done_sync[2] != s_r.done_sync[1]))
    else $error("Result changed without a capture.");

  // The address byte is complete at the fall after its eighth bit.
  sequence addr_byte_done;
    s_r.phase == ST_ADDR && scl_fall && s_r.bitn == 4'h8;
  endsequence
  // The seven address bits agree with the fixed bits and the strap.
  sequence own_address;
    s_r.shift[7:1] == {ADDR_FIXED_BITS, s_r.pin_sync[1]};
  endsequence
  // The seven address bits name some other device.
  sequence foreign_address;
    s_r.shift[7:1] != {ADDR_FIXED_BITS, s_r.pin_sync[1]};
  endsequence
  a_addr_ack: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    addr_byte_done ##0 own_address |=> s_r.sda_drive && s_r.phase == ST_ACK)
    else $error("Own address was not acknowledged.");
  a_addr_refuse: assert property (
    @(posedge sys_clk_i) disable iff (sys_rst_i)
    addr_byte_done ##0 foreign_address |=> !s_r.sda_drive &&
      s_r.phase == ST_IDLE)
    else $error("Foreign address was acknowledged.");
endmodule

// *** test/i2c_master_model.sv ***
// Behavioural serial bus master that drives the sensor's register port.
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Cycles per quarter bit; the bench raises it to act as a slow master.
  int quarter = 8;
  // The bus idles with both lines released.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Every line change lands just after a falling system clock edge.
  task automatic q();
    repeat (quarter) @(negedge clk_i);
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_low_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // Stop: data rises while the clock is high.
  task automatic stop();
    sda_low_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_low_o = 1'b0;
    q();
  endtask
  // One bit; the line is sampled in the middle of the high phase.
  task automatic bit_io(input logic b, output logic s);
    sda_low_o = ~b;
    q();
    scl_o = 1'b1;
    q();
    s = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask
  // Eight bits then a released ninth bit, so a read byte is not acked.
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r,
                         output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      r[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Address, pointer and an optional data byte; a refused address stops.
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [7:0] d, input logic has_data,
                    output logic ack);
    logic [7:0] r;
    logic a;
    start();
    byte_io({dev, 1'b0}, r, ack);
    if (ack) begin
      byte_io(ptr, r, a);
      if (has_data) byte_io(d, r, a);
    end
    stop();
  endtask
  // Pointer write, repeated start, then one byte read back.
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                    output logic [7:0] d);
    logic a;
    start();
    byte_io({dev, 1'b0}, d, a);
    byte_io(ptr, d, a);
    start();
    byte_io({dev, 1'b1}, d, a);
    byte_io(8'hff, d, a);
    stop();
  endtask
endmodule

// *** test/light_sensor_i2c_register_port_test.sv ***
// Self-checking bench for the light sensor serial register port.
`timescale 1ns/1ps
module light_sensor_i2c_register_port_test;
  import light_sensor_pkg::*;
  logic sys_clk_i = 1'b0;
  logic osc_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic osc_rst_i = 1'b1;
  logic addr_pin = 1'b1; // Strap for address bit 0.
  logic photo_pulse_i = 1'b0;
  logic scl, sda_low, sda_o, sda_oe_o, pd, clr;
  logic [1:0] range;
  logic [6:0] dev;
  int failures = 0;
  int total_checks = 0;
  int clr_count = 0; // Interrupt clear pulses seen so far.
  logic [7:0] offs [7] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h03};
  // The data line is pulled up, so it reads high when nobody pulls it.
  wire logic sda_line = ~(sda_low | sda_oe_o);
  assign dev = {ADDR_FIXED_BITS, addr_pin};
  always #4 sys_clk_i = ~sys_clk_i;
  // The oscillator runs at 64 ns with a phase of its own.
  initial #13 forever #32 osc_clk_i = ~osc_clk_i;
  // One charge quantum per oscillator cycle keeps results predictable.
  always @(negedge osc_clk_i) photo_pulse_i <= ~osc_rst_i;
  // Count pulses only when clearly high, so an unknown never counts.
  // Sampled on the falling edge, where the registered pulse has settled.
  always @(negedge sys_clk_i) if (clr === 1'b1) clr_count++;
  light_sensor_i2c_register_port DUT (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .osc_clk_i(osc_clk_i), .osc_rst_i(osc_rst_i),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .address_select_pin_i(addr_pin), .photo_pulse_i(photo_pulse_i),
    .converter_power_down_o(pd), .range_select_o(range),
    .interrupt_clear_o(clr)
  );
  i2c_master_model mst (
    .clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low)
  );
  // Compare with case inequality so unknowns never match.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Print the verdict and end the run.
  task automatic test_done();
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Register write that must be acknowledged.
  task automatic wreg(input logic [7:0] p, input logic [7:0] v);
    logic a;
    mst.wr(dev, p, v, 1'b1, a);
    check(16'(a), 16'h1);
  endtask
  // A low byte and the high byte above it, read in two separate transactions and joined as one word.
  task automatic rd16(input logic [7:0] p, output logic [15:0] v);
    logic [7:0] lo, hi;
    mst.rd(dev, p, lo);
    mst.rd(dev, p + 8'h01, hi);
    v = {hi, lo};
  endtask
  // Guard against a hang anywhere in the main sequence.
  initial begin
    repeat (95000) @(posedge sys_clk_i);
    failures++;
    test_done();
  end
  // Main sequence of bus transactions.
  initial begin
    logic [7:0] d;
    logic [15:0] w, l3, l0;
    logic a;
    int n;
    time t0;
    repeat (20) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge osc_clk_i);
    osc_rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    foreach (offs[i]) begin
      mst.rd(dev, offs[i], d);
      check(16'(d), 16'h0);
    end
    check(16'(sda_o), 16'h0);
    // Both strap levels: the other address must be ignored.
    for (int p = 0; p < 2; p++) begin
      addr_pin = p[0];
      repeat (4) @(negedge sys_clk_i);
      mst.wr({ADDR_FIXED_BITS, ~p[0]}, 8'h00, 8'h00, 1'b0, a);
      check(16'(a), 16'h0);
      mst.wr({ADDR_FIXED_BITS, p[0]}, 8'h00, 8'h00, 1'b0, a);
      check(16'(a), 16'h1);
    end
    // Data registers refuse writes; control bits read back masked.
    wreg(OFS_LIGHT_COUNT_LOW, 8'hff);
    mst.rd(dev, OFS_LIGHT_COUNT_LOW, d);
    check(16'(d), 16'h0);
    wreg(OFS_OPERATION_COMMAND, 8'hff);
    wreg(OFS_GAIN_SETTING, 8'hff);
    check(16'({pd, range}), 16'h7);
    mst.rd(dev, OFS_OPERATION_COMMAND, d);
    check(16'(d), 16'hef);
    mst.rd(dev, OFS_GAIN_SETTING, d);
    check(16'(d), 16'h0c);
    n = clr_count;
    mst.wr(dev, 8'h40, 8'h00, 1'b0, a);
    check(16'(clr_count - n), 16'h1);
    // Internal timing at the two shortest widths, lowest gain weight.
    wreg(OFS_GAIN_SETTING, 8'h0c);
    for (int i = 0; i < 2; i++) begin
      wreg(OFS_OPERATION_COMMAND, 8'h8b - 8'(i));
      repeat (i * 6000 + 600) @(negedge sys_clk_i);
      rd16(OFS_CYCLE_COUNT_LOW, w);
      check(w, i ? 16'd256 : 16'd16);
    end
    wreg(OFS_OPERATION_COMMAND, 8'h8b);
    repeat (600) @(negedge sys_clk_i);
    rd16(OFS_LIGHT_COUNT_LOW, l3);
    check(16'(l3 != 16'h0), 16'h1);
    wreg(OFS_GAIN_SETTING, 8'h00);
    repeat (600) @(negedge sys_clk_i);
    rd16(OFS_LIGHT_COUNT_LOW, l0);
    check(l0, l3 << 3);
    // A disabled converter keeps its last result, whatever the gain.
    wreg(OFS_OPERATION_COMMAND, 8'h83);
    wreg(OFS_GAIN_SETTING, 8'h0c);
    repeat (600) @(negedge sys_clk_i);
    rd16(OFS_LIGHT_COUNT_LOW, w);
    check(w, l0);
    mst.rd(dev, OFS_OPERATION_COMMAND, d);
    check(16'(d), 16'h83);
    // External timing: the period is the spacing of two restarts.
    wreg(OFS_OPERATION_COMMAND, 8'hab);
    t0 = $time;
    mst.wr(dev, 8'h80, 8'h00, 1'b0, a);
    repeat (3000) @(negedge sys_clk_i);
    n = int'(($time - t0) / 64);
    mst.wr(dev, 8'h80, 8'h00, 1'b0, a);
    rd16(OFS_CYCLE_COUNT_LOW, w);
    check(16'(int'(w) > n - 4 && int'(w) < n + 4), 16'h1);
    // A slow master must be served just the same.
    mst.quarter = 20;
    mst.rd(dev, OFS_OPERATION_COMMAND, d);
    check(16'(d), 16'hab);
    mst.quarter = 8;
    test_done();
  end
endmodule
